// ===== rtl/wwtr_pkg.sv
// Constants and types shared by the window watchdog design
package wwtr_pkg;

    // Time base: one millisecond tick derived from the 100 MHz reference clock
    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned MS_NS         = 1000000;
    localparam int unsigned MS_CYCLES_DEF = MS_NS / CLK_PERIOD_NS;
    localparam int unsigned PRE_W         = 17;

    // Millisecond counter width and timing figures in milliseconds
    localparam int unsigned MS_W           = 8;
    localparam logic [7:0]  STARTUP_MS     = 8'h04;
    localparam logic [7:0]  LEAD_MS        = 8'h9b;
    localparam logic [7:0]  RESET_PULSE_MS = 8'h04;

    // Oscillator period limits, in milliseconds
    localparam int unsigned OSC_W      = 7;
    localparam logic [6:0]  OSC_MIN_MS = 7'h14;
    localparam logic [6:0]  OSC_MAX_MS = 7'h40;

    // Watchdog sequence states
    typedef enum logic [4:0] {
        ST_OFF     = 5'b00001,
        ST_STARTUP = 5'b00010,
        ST_LEAD    = 5'b00100,
        ST_WINDOW  = 5'b01000,
        ST_RESET   = 5'b10000
    } wwtr_state_e;

endpackage : wwtr_pkg

// ===== rtl/wwtr_pin_sync.sv
// Three-stage pin synchroniser whose output follows once stages two and three agree
`timescale 1ns/1ps
module wwtr_pin_sync #(
    parameter logic INIT = 1'b1
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic clk_en,
    input  wire logic pin,
    output logic      level
);

    logic s1;
    logic s2;
    logic s3;
    logic next_level;

    always_comb begin
        next_level = level;
        if (s2 == s3) begin
            next_level = s3;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s1    <= INIT;
            s2    <= INIT;
            s3    <= INIT;
            level <= INIT;
        end else if (clk_en) begin
            s1    <= pin;
            s2    <= s1;
            s3    <= s2;
            level <= next_level;
        end
    end

endmodule : wwtr_pin_sync

// ===== rtl/wwtr_watchdog.sv
// Window watchdog with trigger input, open-drain reset output and disable options
//
// What this block does
// RULE_01 - A falling trigger edge counts only while the watchdog runs: during the lead time or in the trigger window.
// RULE_02 - The host holds each trigger pulse low for longer than 7 us.
// RULE_03 - No valid trigger within the window pulls the reset output low.
// RULE_04 - Window timing uses an oscillator period clamped between 20 and 64 ms.
// RULE_05 - In sleep the watchdog stops: no trigger checks, no resets.
// RULE_06 - The disable bit sets only after two consecutive configuration words request it.
// RULE_07 - Divider pin high through the 4 ms start-up starts the watchdog disabled.
// RULE_08 - After undervoltage reset release, wait 155 ms lead time for the first trigger.
// RULE_09 - After sleep exit the lead time starts at the reset pin rising edge.
// RULE_10 - Accepted triggers restart the window; watchdog resets restart the lead time.
`timescale 1ns/1ps
module wwtr_watchdog
    import wwtr_pkg::*;
#(
    parameter int unsigned MS_CYCLES = MS_CYCLES_DEF
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             clk_en,
    input  wire logic             trigger_in_n,
    input  wire logic             divider_out_pin,
    input  wire logic             reset_out_n_in,
    input  wire logic             sleep_mode,
    input  wire logic             vcc_undervoltage,
    input  wire logic             cfg_word_valid,
    input  wire logic             cfg_wd_disable,
    input  wire logic [OSC_W-1:0] wd_osc_period_ms,
    output logic                  reset_out_n,
    output logic                  reset_out_oe,
    output logic                  watchdog_disable_bit,
    output logic                  wd_running
);

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    logic trig_s;
    logic div_s;
    logic reset_out_n_s;

    wwtr_pin_sync #(.INIT(1'b1)) u_sync_trig (
        .ref_clk (ref_clk),
        .rst     (rst),
        .clk_en  (clk_en),
        .pin     (trigger_in_n),
        .level   (trig_s)
    );

    // Starts at the strap level so the synchroniser delay cannot spoil the strap check
    wwtr_pin_sync #(.INIT(1'b1)) u_sync_div (
        .ref_clk (ref_clk),
        .rst     (rst),
        .clk_en  (clk_en),
        .pin     (divider_out_pin),
        .level   (div_s)
    );

    wwtr_pin_sync #(.INIT(1'b0)) u_sync_reset_out_n (
        .ref_clk (ref_clk),
        .rst     (rst),
        .clk_en  (clk_en),
        .pin     (reset_out_n_in),
        .level   (reset_out_n_s)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // State

    wwtr_state_e      state;
    wwtr_state_e      next_state;
    logic [PRE_W-1:0] pre_cnt;
    logic [PRE_W-1:0] next_pre_cnt;
    logic [MS_W-1:0]  ms_cnt;
    logic [MS_W-1:0]  next_ms_cnt;
    logic             lead_run;
    logic             next_lead_run;
    logic             strap_ok;
    logic             next_strap_ok;
    logic             strap_dis;
    logic             next_strap_dis;
    logic             cfg_dis;
    logic             next_cfg_dis;
    logic             cfg_pend;
    logic             next_cfg_pend;
    logic             trig_prev;
    logic             next_reset_out_oe;
    logic             next_watchdog_disable_bit;
    logic             next_wd_running;

    logic             tick;
    logic             trig_fall;
    logic             restart;
    logic             disabled;
    logic [OSC_W-1:0] osc_ms;
    logic [MS_W-1:0]  window_last;

    // Open-drain pin: the driven level is always low, only the enable moves
    assign reset_out_n = 1'b0;

    assign tick      = (pre_cnt == PRE_W'(MS_CYCLES - 1));
    assign trig_fall = trig_prev & ~trig_s;
    assign disabled  = cfg_dis | strap_dis;

    // Oscillator period held inside its adjustable range
    always_comb begin
        osc_ms = wd_osc_period_ms;
        if (wd_osc_period_ms < OSC_MIN_MS) begin
            osc_ms = OSC_MIN_MS; // RULE_04
        end else if (wd_osc_period_ms > OSC_MAX_MS) begin
            osc_ms = OSC_MAX_MS; // RULE_04
        end
        window_last = {1'b0, osc_ms} - 8'h01;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration disable bit

    always_comb begin
        next_cfg_dis  = cfg_dis;
        next_cfg_pend = cfg_pend;
        if (cfg_word_valid) begin
            if (cfg_wd_disable) begin
                next_cfg_pend = 1'b1;
                if (cfg_pend) begin
                    next_cfg_dis = 1'b1; // RULE_06
                end
            end else begin
                next_cfg_pend = 1'b0; // RULE_06
                next_cfg_dis  = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog sequence

    always_comb begin
        next_state     = state;
        next_lead_run  = lead_run;
        next_strap_ok  = strap_ok;
        next_strap_dis = strap_dis;
        restart        = 1'b0;

        unique case (state)
            ST_OFF: begin
                if (!sleep_mode) begin
                    next_state    = ST_STARTUP;
                    next_strap_ok = 1'b1;
                    restart       = 1'b1;
                end
            end
            ST_STARTUP: begin
                next_strap_ok = strap_ok & div_s; // RULE_07
                if (tick && ms_cnt == STARTUP_MS - 8'h01) begin
                    next_strap_dis = strap_ok & div_s; // RULE_07
                    next_state     = ST_LEAD;
                    next_lead_run  = 1'b0;
                    restart        = 1'b1;
                end
            end
            ST_LEAD: begin
                if (disabled || vcc_undervoltage) begin
                    next_lead_run = 1'b0; // RULE_08
                    restart       = 1'b1;
                end else if (!lead_run) begin
                    if (reset_out_n_s) begin
                        next_lead_run = 1'b1; // RULE_09
                        restart       = 1'b1;
                    end
                end else if (trig_fall) begin
                    next_state = ST_WINDOW; // RULE_01
                    restart    = 1'b1;
                end else if (tick && ms_cnt == LEAD_MS - 8'h01) begin
                    next_state = ST_RESET; // RULE_08
                    restart    = 1'b1;
                end
            end
            ST_WINDOW: begin
                if (disabled || vcc_undervoltage) begin
                    next_state    = ST_LEAD;
                    next_lead_run = 1'b0;
                    restart       = 1'b1;
                end else if (trig_fall) begin
                    restart = 1'b1; // RULE_10
                end else if (tick && ms_cnt == window_last) begin
                    next_state = ST_RESET; // RULE_03
                    restart    = 1'b1;
                end
            end
            ST_RESET: begin
                if (tick && ms_cnt == RESET_PULSE_MS - 8'h01) begin
                    next_state    = ST_LEAD; // RULE_10
                    next_lead_run = 1'b0;
                    restart       = 1'b1;
                end
            end
        endcase

        // Sleep overrides everything and stops the watchdog
        if (sleep_mode) begin
            next_state    = ST_OFF; // RULE_05
            next_lead_run = 1'b0;
            restart       = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Millisecond time base, restarted with every timing restart

    always_comb begin
        next_pre_cnt = pre_cnt + PRE_W'(1);
        next_ms_cnt  = ms_cnt;
        if (tick) begin
            next_pre_cnt = '0;
            if (ms_cnt != 8'hff) begin
                next_ms_cnt = ms_cnt + 8'h01;
            end
        end
        if (restart) begin
            next_pre_cnt = '0; // RULE_10
            next_ms_cnt  = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    always_comb begin
        next_reset_out_oe         = (next_state == ST_RESET); // RULE_03
        next_watchdog_disable_bit = next_cfg_dis | next_strap_dis;
        next_wd_running           = (next_state == ST_WINDOW) ||
                                    (next_state == ST_LEAD && next_lead_run);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state                <= ST_OFF;
            pre_cnt              <= '0;
            ms_cnt               <= '0;
            lead_run             <= 1'b0;
            strap_ok             <= 1'b0;
            strap_dis            <= 1'b0;
            cfg_dis              <= 1'b0;
            cfg_pend             <= 1'b0;
            trig_prev            <= 1'b1;
            reset_out_oe         <= 1'b0;
            watchdog_disable_bit <= 1'b0;
            wd_running           <= 1'b0;
        end else if (clk_en) begin
            state                <= next_state;
            pre_cnt              <= next_pre_cnt;
            ms_cnt               <= next_ms_cnt;
            lead_run             <= next_lead_run;
            strap_ok             <= next_strap_ok;
            strap_dis            <= next_strap_dis;
            cfg_dis              <= next_cfg_dis;
            cfg_pend             <= next_cfg_pend;
            trig_prev            <= trig_s;
            reset_out_oe         <= next_reset_out_oe;
            watchdog_disable_bit <= next_watchdog_disable_bit;
            wd_running           <= next_wd_running;
        end
    end

endmodule : wwtr_watchdog

// ===== verification/wwtr_watchdog_sva.sv
// Concurrent checks on the window watchdog ports
`timescale 1ns/1ps
module wwtr_watchdog_sva
    import wwtr_pkg::*;
#(
    parameter int unsigned MS_CYCLES = MS_CYCLES_DEF
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic trigger_in_n,
    input wire logic divider_out_pin,
    input wire logic sleep_mode,
    input wire logic cfg_word_valid,
    input wire logic cfg_wd_disable,
    input wire logic reset_out_n,
    input wire logic reset_out_oe,
    input wire logic watchdog_disable_bit,
    input wire logic wd_running
);
    logic        pend;
    logic        trig_q;
    int unsigned oe_cnt;
    int unsigned quiet;
    ////////////////////////////////////////////////////////////////////////////////
    // Pending disable word, reset pulse length and cycles since the last trigger
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pend   <= 1'b0;
            trig_q <= 1'b1;
            oe_cnt <= 0;
            quiet  <= 0;
        end else begin
            trig_q <= trigger_in_n;
            if (cfg_word_valid && clk_en)
                pend <= cfg_wd_disable;
            if (!reset_out_oe)
                oe_cnt <= 0;
            else if (clk_en)
                oe_cnt <= oe_cnt + 1;
            if (!wd_running || reset_out_oe || (trig_q && !trigger_in_n))
                quiet <= 0;
            else if (clk_en)
                quiet <= quiet + 1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_sleep_no_reset: assert property (sleep_mode && clk_en |=> !reset_out_oe)
        else $error("reset pulled during sleep");
    a_sleep_stopped: assert property (sleep_mode && clk_en |=> !wd_running)
        else $error("watchdog running during sleep");
    a_pin_low: assert property (reset_out_oe |-> reset_out_n == 1'b0)
        else $error("reset pin not driven low");
    a_pulse_length: assert property ($fell(reset_out_oe) && !$past(sleep_mode) |->
        oe_cnt == RESET_PULSE_MS * MS_CYCLES) else $error("reset pulse length wrong");
    a_single_write: assert property (cfg_word_valid && clk_en && cfg_wd_disable && !pend
        && !divider_out_pin && !watchdog_disable_bit |=> !watchdog_disable_bit)
        else $error("disabled by one word");
    a_double_write: assert property (cfg_word_valid && clk_en && cfg_wd_disable && pend
        |=> watchdog_disable_bit) else $error("second word did not disable");
    a_disabled_quiet: assert property ($past(watchdog_disable_bit) |->
        !$rose(reset_out_oe)) else $error("reset while disabled");
    a_lead_bound: assert property (wd_running && !watchdog_disable_bit |->
        quiet < LEAD_MS * MS_CYCLES + 20) else $error("no reset after missing trigger");
    a_no_early_reset: assert property ($rose(reset_out_oe) |->
        quiet >= OSC_MIN_MS * MS_CYCLES) else $error("reset before shortest window");
endmodule : wwtr_watchdog_sva

bind wwtr_watchdog wwtr_watchdog_sva #(.MS_CYCLES(MS_CYCLES)) wwtr_watchdog_sva_inst (
    .ref_clk, .rst, .clk_en, .trigger_in_n, .divider_out_pin, .sleep_mode, .cfg_word_valid,
    .cfg_wd_disable, .reset_out_n, .reset_out_oe, .watchdog_disable_bit, .wd_running);

// ===== verification/wwtr_host_model.sv
// Host model that answers a request with a low pulse on the trigger pin
`timescale 1ns/1ps
module wwtr_host_model #(
    parameter int PULSE_CYC = 8
) (
    input  wire logic ref_clk,
    input  wire logic pulse_req,
    output logic      trigger_in_n
);
    int cnt = 0;
    always @(posedge ref_clk) begin
        if (pulse_req)
            cnt <= PULSE_CYC;
        else if (cnt != 0)
            cnt <= cnt - 1;
    end
    assign trigger_in_n = (cnt == 0);
endmodule : wwtr_host_model

// ===== verification/wwtr_watchdog_tb_top.sv
// Self-checking testbench of the window watchdog
`timescale 1ns/1ps
module wwtr_watchdog_tb_top;
    import wwtr_pkg::*;
    localparam int MSC = 10;
    localparam int LEAD = LEAD_MS * MSC;
    localparam int PULSE = RESET_PULSE_MS * MSC;
    logic ref_clk = 0, rst = 1, clk_en = 1, req = 0, divider_out_pin = 0, sleep_mode = 0;
    logic vcc_undervoltage = 0, cfg_word_valid = 0, cfg_wd_disable = 0;
    logic [OSC_W-1:0] wd_osc_period_ms = 7'h1e;
    logic trigger_in_n, reset_out_n, reset_out_oe, watchdog_disable_bit, wd_running;
    int   num_errors = 0;
    int   compares = 0;
    int   n;
    int   osc_tab [3] = '{10, 30, 100};
    int   exp_tab [3] = '{200, 300, 640};
    // Open-drain reset wire with pull-up
    wire  reset_out_n_in = reset_out_oe ? reset_out_n : 1'b1;
    initial forever #5 ref_clk = ~ref_clk;
    wwtr_host_model wwtr_host_model_inst (.ref_clk, .pulse_req(req), .trigger_in_n);
    wwtr_watchdog #(.MS_CYCLES(MSC)) wwtr_watchdog_inst (.ref_clk, .rst, .clk_en,
        .trigger_in_n, .divider_out_pin, .reset_out_n_in, .sleep_mode, .vcc_undervoltage,
        .cfg_word_valid, .cfg_wd_disable, .wd_osc_period_ms, .reset_out_n, .reset_out_oe,
        .watchdog_disable_bit, .wd_running);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic tick(input int c);
        repeat (c) @(negedge ref_clk);
    endtask : tick
    task automatic complete_run;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : complete_run
    task automatic check_bit(input logic got, input logic exp, input string what);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask : check_bit
    task automatic check_range(input int got, input int lo, input int hi, input string what);
        compares++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("unexpected at %0t: %s took %0d", $time, what, got);
        end
    endtask : check_range
    // Cycles until the reset drive reaches a level, bounded
    task automatic wait_oe(input logic lvl, output int c);
        c = 0;
        while (reset_out_oe !== lvl) begin
            tick(1);
            c++;
            if (c > 4000) begin
                num_errors++;
                $display("unexpected at %0t: reset drive wait ran out", $time);
                complete_run();
            end
        end
    endtask : wait_oe
    task automatic do_reset;
        rst = 1'b1;
        tick(20);
        rst = 1'b0;
    endtask : do_reset
    task automatic trig;
        req = 1'b1;
        tick(1);
        req = 1'b0;
    endtask : trig
    task automatic cfg(input logic b);
        cfg_word_valid = 1'b1;
        cfg_wd_disable = b;
        tick(1);
        cfg_word_valid = 1'b0;
        tick(4);
    endtask : cfg
    // Reset drive must stay off for c cycles
    task automatic stay_quiet(input int c);
        logic bad;
        bad = 1'b0;
        repeat (c) begin
            tick(1);
            if (reset_out_oe !== 1'b0)
                bad = 1'b1;
        end
        check_bit(bad, 1'b0, "reset drive while stopped");
    endtask : stay_quiet
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_lead;
        do_reset();
        tick(100);
        check_bit(wd_running, 1'b1, "not running in lead");
        wait_oe(1'b1, n);
        check_range(n + 100, LEAD + 40, LEAD + 52, "first lead");
        tick(20);
        check_bit(wd_running, 1'b0, "running during reset pulse");
        check_bit(reset_out_n, 1'b0, "reset pin not driven low");
        wait_oe(1'b0, n);
        wait_oe(1'b1, n);
        check_range(n, LEAD, LEAD + 12, "lead after watchdog reset");
        $display("t_lead done");
    endtask : t_lead
    task automatic t_window;
        do_reset();
        tick(100);
        for (int i = 0; i < 3; i++) begin
            wd_osc_period_ms = osc_tab[i][OSC_W-1:0];
            trig();
            tick(exp_tab[i] - 60);
            trig();
            wait_oe(1'b1, n);
            check_range(n, exp_tab[i] - 2, exp_tab[i] + 10, "window expiry");
            wait_oe(1'b0, n);
            tick(20);
        end
        $display("t_window done");
    endtask : t_window
    task automatic t_sleep;
        do_reset();
        tick(100);
        vcc_undervoltage = 1'b1;
        tick(3);
        check_bit(wd_running, 1'b0, "running in undervoltage");
        vcc_undervoltage = 1'b0;
        trig();
        tick(50);
        sleep_mode = 1'b1;
        tick(2);
        stay_quiet(800);
        check_bit(wd_running, 1'b0, "running in sleep");
        sleep_mode = 1'b0;
        wait_oe(1'b1, n);
        check_range(n, LEAD + 40, LEAD + 52, "lead after wake-up");
        clk_en = 1'b0;
        tick(100);
        check_bit(reset_out_oe, 1'b1, "reset pulse ran while frozen");
        clk_en = 1'b1;
        wait_oe(1'b0, n);
        check_range(n, PULSE - 1, PULSE + 1, "pulse after freeze");
        $display("t_sleep done");
    endtask : t_sleep
    task automatic t_cfg;
        do_reset();
        tick(10);
        cfg(1'b1);
        cfg(1'b0);
        cfg(1'b1);
        check_bit(watchdog_disable_bit, 1'b0, "disabled by one word");
        cfg(1'b1);
        check_bit(watchdog_disable_bit, 1'b1, "two words did not disable");
        stay_quiet(2000);
        cfg(1'b0);
        check_bit(watchdog_disable_bit, 1'b0, "clearing word ignored");
        $display("t_cfg done");
    endtask : t_cfg
    task automatic t_strap;
        divider_out_pin = 1'b1;
        do_reset();
        tick(60);
        divider_out_pin = 1'b0;
        tick(5);
        check_bit(watchdog_disable_bit, 1'b1, "strap did not disable");
        divider_out_pin = 1'b1;
        do_reset();
        tick(20);
        divider_out_pin = 1'b0;
        tick(45);
        check_bit(watchdog_disable_bit, 1'b0, "short strap disabled");
        $display("t_strap done");
    endtask : t_strap
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        tick(1);
        t_lead();
        t_window();
        t_sleep();
        t_cfg();
        t_strap();
        complete_run();
    end
endmodule : wwtr_watchdog_tb_top
